// ===== core/ppm_pkg.sv
package ppm_pkg;

  // Clock rates
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MII_HZ_10 = 2_500_000;
  localparam int unsigned MII_HZ_100 = 25_000_000;
  localparam int unsigned MGMT_MAX_HZ = 20_000_000;
  localparam int unsigned DIV_10 = CLK_HZ / MII_HZ_10;

  // Line code sent in place of data on a transmit error
  localparam logic [4:0] H_SYMBOL = 5'h04;

  // Register byte offsets on the Avalon side
  localparam int unsigned AV_AW = 4;
  localparam logic [AV_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [AV_AW-1:0] OFF_STAT = 4'h4;
  localparam logic [AV_AW-1:0] OFF_ADDR = 4'h8;

  // Control register fields
  localparam int unsigned CTL_W = 4;
  localparam int unsigned CTL_SPEED100 = 0;
  localparam int unsigned CTL_FULL = 1;
  localparam int unsigned CTL_SYMBOL = 2;
  localparam int unsigned CTL_FIBER = 3;
  localparam logic [CTL_W-1:0] CTL_RESET = 4'h1;

  // Status register fields
  localparam int unsigned ST_W = 6;
  localparam int unsigned ST_COL = 0;
  localparam int unsigned ST_CRS = 1;
  localparam int unsigned ST_SD = 2;
  localparam int unsigned ST_STRAP = 3;
  localparam int unsigned ST_TXACT = 4;
  localparam int unsigned ST_RXACT = 5;

  // Strap capture delay after reset release
  localparam logic [1:0] CFG_SETTLE = 2'h3;
  localparam logic [1:0] CFG_LOAD_AT = 2'h1;

  // Serial management frame
  localparam logic [5:0] MD_PRE_LEN = 6'h20;
  localparam logic [5:0] MD_HDR_LAST = 6'h0b;
  localparam logic [5:0] MD_TA_LAST = 6'h01;
  localparam logic [5:0] MD_DATA_LAST = 6'h0f;
  localparam logic [5:0] MD_DATA_END = 6'h10;
  localparam logic [1:0] MD_OP_READ = 2'h2;
  localparam logic [1:0] MD_OP_WRITE = 2'h1;
  localparam logic [4:0] MREG_CTRL = 5'h00;
  localparam logic [4:0] MREG_STAT = 5'h01;
  localparam logic [4:0] MREG_ADDR = 5'h02;

  typedef enum logic [2:0] {MS_PRE, MS_START, MS_HDR, MS_TA, MS_RDATA, MS_WDATA} ppm_mgmt_state_t;

  // Register view shared by the Avalon and serial management paths
  function automatic logic [15:0] ppm_reg_view(input logic [4:0] idx, input logic [CTL_W-1:0] ctl,
                                               input logic [ST_W-1:0] st, input logic [4:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      MREG_CTRL: v[CTL_W-1:0] = ctl;
      MREG_STAT: v[ST_W-1:0] = st;
      MREG_ADDR: v[4:0] = addr;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

endpackage

// ===== core/ppm_mgmt_serial.sv
`timescale 1ns/1ps
module ppm_mgmt_serial
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic [4:0] phy_addr,
  // Synchronised serial pins
  input wire logic mdc_rise,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Register access
  output logic [4:0] reg_addr,
  input wire logic [15:0] rd_data,
  output logic wr_pulse,
  output logic [15:0] wr_data
);

  ppm_mgmt_state_t state_q;
  logic [5:0] cnt_q;
  logic [11:0] hdr_q;
  logic [11:0] hdr_d;
  logic is_read_q;
  logic [15:0] shift_q;
  logic wr_pulse_q;
  logic [15:0] wr_data_q;
  logic out_q;
  logic oe_q;

  assign hdr_d = {hdr_q[10:0], mdio_in};
  assign reg_addr = hdr_q[4:0];
  assign wr_pulse = wr_pulse_q;
  assign wr_data = wr_data_q;
  assign mdio_out = out_q;
  assign mdio_oe = oe_q;

  // Frame sequencer; a frame for another address drops back to preamble hunting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MS_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 12'h000;
      is_read_q <= 1'b0;
    end else if (!enable) begin
      state_q <= MS_PRE; // RULE18
      cnt_q <= 6'h00;
    end else if (mdc_rise) begin
      case (state_q)
        MS_PRE: begin
          if (mdio_in) begin
            if (cnt_q != MD_PRE_LEN) begin
              cnt_q <= cnt_q + 6'h01;
            end
          end else if (cnt_q == MD_PRE_LEN) begin
            state_q <= MS_START;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        MS_START: begin
          cnt_q <= 6'h00;
          state_q <= mdio_in ? MS_HDR : MS_PRE;
        end
        MS_HDR: begin
          hdr_q <= hdr_d;
          if (cnt_q == MD_HDR_LAST) begin
            cnt_q <= 6'h00;
            is_read_q <= (hdr_d[11:10] == MD_OP_READ);
            if (hdr_d[9:5] == phy_addr && (hdr_d[11:10] == MD_OP_READ || hdr_d[11:10] == MD_OP_WRITE)) begin
              state_q <= MS_TA; // RULE22
            end else begin
              state_q <= MS_PRE;
            end
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        MS_TA: begin
          if (is_read_q) begin
            state_q <= MS_RDATA;
            cnt_q <= 6'h00;
          end else if (cnt_q == MD_TA_LAST) begin
            state_q <= MS_WDATA;
            cnt_q <= 6'h00;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        MS_RDATA: begin
          if (cnt_q == MD_DATA_END) begin
            state_q <= MS_PRE;
            cnt_q <= 6'h00;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        MS_WDATA: begin
          if (cnt_q == MD_DATA_LAST) begin
            state_q <= MS_PRE;
            cnt_q <= 6'h00;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        default: begin
          state_q <= MS_PRE;
          cnt_q <= 6'h00;
        end
      endcase
    end
  end

  // Data shifter: read word captured at turnaround, write word assembled msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 16'h0000;
    end else if (mdc_rise) begin
      if (state_q == MS_TA && is_read_q) begin
        shift_q <= rd_data;
      end else if (state_q == MS_RDATA && cnt_q != MD_DATA_END) begin
        shift_q <= {shift_q[14:0], 1'b0};
      end else if (state_q == MS_WDATA) begin
        shift_q <= {shift_q[14:0], mdio_in};
      end
    end
  end

  // Write strobe, one clock wide, after the last data bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse_q <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      wr_pulse_q <= enable && mdc_rise && state_q == MS_WDATA && cnt_q == MD_DATA_LAST;
      if (enable && mdc_rise && state_q == MS_WDATA && cnt_q == MD_DATA_LAST) begin
        wr_data_q <= {shift_q[14:0], mdio_in};
      end
    end
  end

  // Pin driver: zero in the second turnaround bit, then sixteen data bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!enable) begin
      oe_q <= 1'b0; // RULE18
    end else if (mdc_rise) begin
      if (state_q == MS_TA && is_read_q) begin
        oe_q <= 1'b1;
        out_q <= 1'b0;
      end else if (state_q == MS_RDATA && cnt_q != MD_DATA_END) begin
        out_q <= shift_q[15];
      end else begin
        oe_q <= 1'b0;
        out_q <= 1'b0;
      end
    end
  end

endmodule

// ===== core/ppm_mii_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: MAC changes the transmit nibble in step with our transmit clock.
// RULE2: Bit 0 of transmit and receive nibbles is the least significant.
// RULE3: Normal mode takes only four transmit data bits, error is not data.
// RULE4: Symbol mode uses transmit error as fifth transmit data bit.
// RULE5: MAC raises transmit enable with frame data, synchronous to transmit clock.
// RULE6: MAC flags transmit stream errors; meaningful only at 100 Mbps.
// RULE7: At 100 Mbps a transmit error sends H symbols on the line.
// RULE8: Transmit clock is generated here, 2.5 MHz or 25 MHz.
// RULE9: Receive clock is generated here, 2.5 MHz or 25 MHz.
// RULE10: Receive nibble changes in step with the receive clock.
// RULE11: Receive valid is high exactly while the nibble carries valid data.
// RULE12: Receive error rises on invalid symbols from the network.
// RULE13: Symbol mode uses receive error as fifth receive data bit.
// RULE14: Collision output stays high for the whole collision.
// RULE15: Collision output stays low in full duplex.
// RULE16: Half duplex carrier sense follows transmit or receive activity.
// RULE17: Full duplex carrier sense follows receive activity only.
// RULE18: Strap high disables management port; pins load bits at every reset.
// RULE19: Strap low: pins give defaults only, management then owns the bits.
// RULE20: Management clock must not exceed 20 MHz; the edge sampler here needs it under clk/4.
// RULE21: Fiber mode qualifies reception by signal detect; twisted pair ignores it.
// RULE22: Port address is strap bits above a fixed lowest bit per port.
// RULE23: At 10 Mbps transmit error is ignored and symbols are unaffected; in symbol mode the code still sends it as the fifth code bit.
module ppm_mii_port
  import ppm_pkg::*;
#(
  parameter logic PORT_INDEX = 1'b0,
  parameter int unsigned DIV10 = DIV_10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [AV_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // MII transmit
  output logic tx_clock_out,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_frame_enable,
  input wire logic tx_error_in,
  // MII receive and status
  output logic rx_clock_out,
  output logic [3:0] rx_nibble,
  output logic rx_valid_out,
  output logic rx_error_out,
  output logic collision_out,
  output logic carrier_sense_out,
  // Serial management and straps
  input wire logic mgmt_disable_strap,
  input wire logic mgmt_serial_clock,
  input wire logic mgmt_serial_data_in,
  output logic mgmt_serial_data_out,
  output logic mgmt_serial_data_oe,
  input wire logic [3:0] phy_addr_strap,
  input wire logic [CTL_W-1:0] cfg_pins,
  // Fiber signal detect
  input wire logic fiber_signal_detect,
  // Line coding side
  output logic [4:0] line_tx_code,
  output logic line_tx_valid,
  input wire logic [4:0] line_rx_code,
  input wire logic line_rx_valid,
  input wire logic line_rx_invalid,
  input wire logic line_rx_active
);

  localparam int unsigned SYNC_W = 8 + CTL_W;
  localparam logic [7:0] DIV_LAST = 8'(DIV10 - 1);
  localparam logic [7:0] DIV_HALF = 8'(DIV10 / 2 - 1);

  // The divider must yield a clock with two distinct phases
  if (DIV10 < 2 || DIV10 > 256 || (DIV10 % 2) != 0) begin : g_div_check
    $error("DIV10 must be even and between 2 and 256");
  end

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic strap_s;
  logic mdc_s;
  logic mdio_s;
  logic sd_s;
  logic [CTL_W-1:0] cfg_s;
  logic [3:0] addr_s;
  logic mdc_prev_q;
  logic mdc_rise;
  logic [1:0] settle_q;
  logic [CTL_W-1:0] ctl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic av_wr;
  logic [4:0] phy_addr;
  logic [ST_W-1:0] status;
  logic [4:0] md_reg_addr;
  logic [15:0] md_rd_data;
  logic md_wr_pulse;
  logic [15:0] md_wr_data;
  logic [7:0] div_q;
  logic clk10_q;
  logic mii_tick;
  logic speed100;
  logic full_dup;
  logic symbol_mode;
  logic sd_ok;
  logic rx_busy;
  logic [4:0] tx_code_q;
  logic tx_valid_q;
  logic [3:0] rx_nibble_q;
  logic rx_valid_q;
  logic rx_error_q;
  logic col_q;
  logic crs_q;

  // Two-flop synchronisers for every pin from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {mgmt_disable_strap, mgmt_serial_clock, mgmt_serial_data_in, fiber_signal_detect,
                  phy_addr_strap, cfg_pins};
      sync2_q <= sync1_q;
    end
  end

  assign {strap_s, mdc_s, mdio_s, sd_s, addr_s, cfg_s} = sync2_q;

  // Management clock edge finder; 20 MHz is the part's limit but this sampler needs under clk/4
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_prev_q; // RULE20

  // Port address: strap bits above, port index as the fixed lowest bit
  assign phy_addr = {addr_s, PORT_INDEX}; // RULE22

  // Strap pins are caught only once the synchronisers hold real pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= CFG_SETTLE;
    end else if (settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end
  end

  // Avalon slave: one wait state, read data registered for the answering edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign av_wr = avs_write && ack_q && avs_byteenable[0] && avs_address == OFF_CTRL;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q) begin
        case (avs_address)
          OFF_CTRL: rdata_q <= {16'h0000, ppm_reg_view(MREG_CTRL, ctl_q, status, phy_addr)};
          OFF_STAT: rdata_q <= {16'h0000, ppm_reg_view(MREG_STAT, ctl_q, status, phy_addr)};
          OFF_ADDR: rdata_q <= {16'h0000, ppm_reg_view(MREG_ADDR, ctl_q, status, phy_addr)};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Control bits: pins load them after reset; strap high keeps software out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= CTL_RESET;
    end else if (settle_q == CFG_LOAD_AT) begin
      ctl_q <= cfg_s; // RULE18 RULE19
    end else if (settle_q == 2'h0 && !strap_s) begin
      if (av_wr) begin
        ctl_q <= avs_writedata[CTL_W-1:0]; // RULE19
      end else if (md_wr_pulse && md_reg_addr == MREG_CTRL) begin
        ctl_q <= md_wr_data[CTL_W-1:0]; // RULE19
      end
    end
  end

  assign speed100 = ctl_q[CTL_SPEED100];
  assign full_dup = ctl_q[CTL_FULL];
  assign symbol_mode = ctl_q[CTL_SYMBOL];

  assign status = {rx_busy, tx_frame_enable, strap_s, sd_s, crs_q, col_q};
  assign md_rd_data = ppm_reg_view(md_reg_addr, ctl_q, status, phy_addr);

  ppm_mgmt_serial u_mgmt (
    .clk(clk),
    .rst_n(rst_n),
    .enable(!strap_s && settle_q == 2'h0),
    .phy_addr(phy_addr),
    .mdc_rise(mdc_rise),
    .mdio_in(mdio_s),
    .mdio_out(mgmt_serial_data_out),
    .mdio_oe(mgmt_serial_data_oe),
    .reg_addr(md_reg_addr),
    .rd_data(md_rd_data),
    .wr_pulse(md_wr_pulse),
    .wr_data(md_wr_data)
  );

  // 10 Mbps divider; the phase falls at the tick so data is settled by the next rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      clk10_q <= 1'b1;
    end else begin
      div_q <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
      if (div_q == DIV_LAST) begin
        clk10_q <= 1'b1;
      end else if (div_q == DIV_HALF) begin
        clk10_q <= 1'b0;
      end
    end
  end

  // At 100 Mbps the core clock itself is the interface clock; switching speed may glitch it
  assign mii_tick = speed100 || div_q == DIV_HALF;
  assign tx_clock_out = speed100 ? clk : clk10_q; // RULE8
  assign rx_clock_out = speed100 ? clk : clk10_q; // RULE9

  // Transmit nibble comes from the MAC on our own clock, so it is taken unsynchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_code_q <= 5'h00;
      tx_valid_q <= 1'b0;
    end else if (mii_tick) begin
      tx_valid_q <= tx_frame_enable; // RULE1 RULE5
      if (symbol_mode) begin
        tx_code_q <= {tx_error_in, tx_nibble}; // RULE4 RULE2
      end else if (speed100 && tx_error_in && tx_frame_enable) begin
        tx_code_q <= H_SYMBOL; // RULE7 RULE6
      end else begin
        tx_code_q <= {1'b0, tx_nibble}; // RULE3 RULE23
      end
    end
  end

  assign line_tx_code = tx_code_q;
  assign line_tx_valid = tx_valid_q;

  // In fiber mode a lost signal detect silences reception
  assign sd_ok = !ctl_q[CTL_FIBER] || sd_s; // RULE21
  assign rx_busy = line_rx_active && sd_ok;

  // Receive outputs move on the interface clock's falling phase at 10 Mbps, on every core clock at 100 Mbps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_nibble_q <= 4'h0;
      rx_valid_q <= 1'b0;
      rx_error_q <= 1'b0;
    end else if (mii_tick) begin
      rx_valid_q <= line_rx_valid && sd_ok; // RULE11 RULE10
      rx_nibble_q <= (line_rx_valid && sd_ok) ? line_rx_code[3:0] : 4'h0; // RULE2 RULE10
      if (symbol_mode) begin
        rx_error_q <= line_rx_code[4] && sd_ok; // RULE13
      end else begin
        rx_error_q <= line_rx_invalid && sd_ok; // RULE12
      end
    end
  end

  assign rx_nibble = rx_nibble_q;
  assign rx_valid_out = rx_valid_q;
  assign rx_error_out = rx_error_q;

  // Collision and carrier follow the media every core clock, not the interface tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_q <= 1'b0;
      crs_q <= 1'b0;
    end else begin
      col_q <= !full_dup && rx_busy && tx_frame_enable; // RULE14 RULE15
      crs_q <= full_dup ? rx_busy : (rx_busy || tx_frame_enable); // RULE16 RULE17
    end
  end

  assign collision_out = col_q;
  assign carrier_sense_out = crs_q;

endmodule

// ===== tb/ppm_mii_port_asserts.sv
`timescale 1ns/1ps
module ppm_mii_port_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // MII and line side
  input wire logic tx_clock_out,
  input wire logic rx_clock_out,
  input wire logic tx_frame_enable,
  input wire logic line_tx_valid,
  input wire logic line_rx_active,
  input wire logic line_rx_valid,
  input wire logic line_rx_invalid,
  input wire logic [4:0] line_rx_code,
  input wire logic [3:0] rx_nibble,
  input wire logic rx_valid_out,
  input wire logic rx_error_out,
  input wire logic collision_out,
  input wire logic carrier_sense_out,
  // Management
  input wire logic mgmt_disable_strap,
  input wire logic mgmt_serial_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A request still waiting for its answer
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  // Strap held long enough to pass the pin synchroniser
  sequence s_strap_held; mgmt_disable_strap [*6]; endsequence
  property p_wait_one; s_req |=> !avs_waitrequest; endproperty
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  property p_col_cause; collision_out |-> $past(tx_frame_enable && line_rx_active); endproperty
  property p_col_crs; collision_out |-> carrier_sense_out; endproperty
  property p_crs_cause; carrier_sense_out |-> $past(tx_frame_enable || line_rx_active); endproperty
  property p_rx_zero; !rx_valid_out |-> rx_nibble == 4'h0; endproperty
  property p_rxv_rise; $rose(rx_valid_out) |-> $past(line_rx_valid); endproperty
  property p_rxe_rise; $rose(rx_error_out) |-> $past(line_rx_invalid || line_rx_code[4]); endproperty
  property p_txv_rise; $rose(line_tx_valid) |-> $past(tx_frame_enable); endproperty
  property p_clk_pair; tx_clock_out == rx_clock_out; endproperty
  property p_strap_off; s_strap_held |-> !mgmt_serial_data_oe; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low in second cycle");
  a_idle: assert property (p_idle) else $error("waitrequest high without request");
  a_col_cause: assert property (p_col_cause) else $error("collision without both activities");
  a_col_crs: assert property (p_col_crs) else $error("collision without carrier");
  a_crs_cause: assert property (p_crs_cause) else $error("carrier without activity");
  a_rx_zero: assert property (p_rx_zero) else $error("receive nibble set while not valid");
  a_rxv_rise: assert property (p_rxv_rise) else $error("receive valid without line valid");
  a_rxe_rise: assert property (p_rxe_rise) else $error("receive error without cause");
  a_txv_rise: assert property (p_txv_rise) else $error("code valid without enable");
  a_clk_pair: assert property (p_clk_pair) else $error("interface clocks differ");
  a_strap_off: assert property (p_strap_off) else $error("data driven with strap high");
endmodule

bind ppm_mii_port ppm_mii_port_asserts u_ppm_mii_port_asserts (
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .tx_clock_out(tx_clock_out), .rx_clock_out(rx_clock_out), .tx_frame_enable(tx_frame_enable),
  .line_tx_valid(line_tx_valid), .line_rx_active(line_rx_active), .line_rx_valid(line_rx_valid),
  .line_rx_invalid(line_rx_invalid), .line_rx_code(line_rx_code), .rx_nibble(rx_nibble),
  .rx_valid_out(rx_valid_out), .rx_error_out(rx_error_out), .collision_out(collision_out),
  .carrier_sense_out(carrier_sense_out), .mgmt_disable_strap(mgmt_disable_strap),
  .mgmt_serial_data_oe(mgmt_serial_data_oe)
);

// ===== tb/ppm_mac_model.sv
`timescale 1ns/1ps
module ppm_mac_model (
  // Interface clock from the port
  input wire logic tx_clock_out,
  // Values wanted on the wire
  input wire logic [3:0] want_nibble,
  input wire logic want_enable,
  input wire logic want_error,
  // MII transmit pins
  output logic [3:0] tx_nibble,
  output logic tx_frame_enable,
  output logic tx_error_in
);
  // Launch on the rising edge, sampled half a period later at 10 Mbps; unknown only until the first clock in reset
  always @(posedge tx_clock_out) begin
    tx_nibble <= want_nibble;
    tx_frame_enable <= want_enable;
    tx_error_in <= want_error;
  end
endmodule

// ===== tb/ppm_mii_port_tb.sv
`timescale 1ns/1ps
module ppm_mii_port_tb;
  import ppm_pkg::*;
  typedef struct packed {
    logic [3:0] ctl; logic [3:0] nib; logic en; logic err; logic sd; logic act;
    logic vld; logic inv; logic x_rxe; logic x_rxv; logic [7:0] code; logic [7:0] x_code;
    logic [3:0] x_rxn; logic x_col; logic x_crs; logic [1:0] pad;
  } ppm_row_t;
  // Mode, inputs and expected outputs per row
  ppm_row_t rows [9] = '{40'h1ab9050a5c, 40'h13e0000404, 40'h36b9090694, 40'h36a0000600, 40'h5cfb131c3c,
                         40'h101f020024, 40'h9018070000, 40'h9039070074, 40'h05e0000504};
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic tx_clock_out, rx_clock_out, tx_frame_enable, tx_error_in;
  logic [3:0] tx_nibble, rx_nibble, want_nibble, cfg_pins;
  logic want_enable, want_error, rx_valid_out, rx_error_out, collision_out, carrier_sense_out;
  logic strap, md_clk, md_out, md_oe, st_oe, st_d, mdio, sd, line_tx_valid;
  logic [4:0] line_tx_code, rx_code;
  logic rx_vld, rx_inv, rx_act;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int i;
  logic [15:0] cnt;
  // Shared data line, pulled up when nobody drives it
  assign mdio = md_oe ? md_out : (st_oe ? st_d : 1'b1);

  ppm_mii_port u_ppm_mii_port (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_clock_out(tx_clock_out), .tx_nibble(tx_nibble),
    .tx_frame_enable(tx_frame_enable), .tx_error_in(tx_error_in), .rx_clock_out(rx_clock_out),
    .rx_nibble(rx_nibble), .rx_valid_out(rx_valid_out), .rx_error_out(rx_error_out),
    .collision_out(collision_out), .carrier_sense_out(carrier_sense_out), .mgmt_disable_strap(strap),
    .mgmt_serial_clock(md_clk), .mgmt_serial_data_in(mdio), .mgmt_serial_data_out(md_out),
    .mgmt_serial_data_oe(md_oe), .phy_addr_strap(4'h5), .cfg_pins(cfg_pins), .fiber_signal_detect(sd),
    .line_tx_code(line_tx_code), .line_tx_valid(line_tx_valid), .line_rx_code(rx_code),
    .line_rx_valid(rx_vld), .line_rx_invalid(rx_inv), .line_rx_active(rx_act)
  );
  ppm_mac_model u_ppm_mac_model (
    .tx_clock_out(tx_clock_out), .want_nibble(want_nibble), .want_enable(want_enable),
    .want_error(want_error), .tx_nibble(tx_nibble), .tx_frame_enable(tx_frame_enable),
    .tx_error_in(tx_error_in)
  );

  // Core clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // One management bit, 320 ns period; sample just before the rising edge
  task automatic md_bit(input logic b, output logic s);
    md_clk <= 1'b0;
    st_d <= b;
    repeat (4) @(posedge clk);
    s = mdio;
    md_clk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // One serial frame; the station drives turnaround and data only on a write, so a write reads back its own word
  task automatic md_frame(input logic [1:0] op, input logic [4:0] rg, input logic [15:0] wd, input logic [15:0] exp);
    logic [13:0] hdr;
    logic [17:0] w;
    logic [17:0] r;
    logic s;
    hdr = {2'b01, op, 4'h5, 1'b0, rg};
    w = {2'b10, wd};
    r = 18'h0;
    st_oe <= 1'b1;
    repeat (32) md_bit(1'b1, s);
    for (i = 13; i >= 0; i--) md_bit(hdr[i], s);
    st_oe <= (op == MD_OP_WRITE);
    for (i = 17; i >= 0; i--) begin
      md_bit(w[i], s);
      r = {r[16:0], s};
    end
    st_oe <= 1'b0;
    @(posedge clk);
    chk(r[15:0], exp);
    $display("serial frame done");
  endtask

  task automatic do_reset(input logic st, input logic [3:0] pins);
    rst_n <= 1'b0;
    strap <= st;
    cfg_pins <= pins;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0;
    want_nibble = 4'h0; want_enable = 1'b0; want_error = 1'b0; strap = 1'b0; cfg_pins = 4'h3;
    md_clk = 1'b1; st_oe = 1'b0; st_d = 1'b1; sd = 1'b1;
    rx_code = 5'h00; rx_vld = 1'b0; rx_inv = 1'b0; rx_act = 1'b0;
    do_reset(1'b0, 4'h3);
    av(1'b0, OFF_CTRL, 32'h0, q);
    chk(q[15:0], 16'h0003);
    av(1'b0, OFF_ADDR, 32'h0, q);
    chk(q[15:0], 16'h000a);
    av(1'b1, 4'hc, 32'hffff_ffff, q);
    av(1'b0, 4'hc, 32'h0, q);
    chk(q[15:0], 16'h0000);
    md_frame(MD_OP_READ, MREG_ADDR, 16'h0000, 16'h000a);
    md_frame(MD_OP_WRITE, MREG_CTRL, 16'h0009, 16'h0009);
    av(1'b0, OFF_CTRL, 32'h0, q);
    chk(q[15:0], 16'h0009);
    // Mode rows; the last one leaves the port at 10 Mbps
    for (int k = 0; k < 9; k++) begin
      av(1'b1, OFF_CTRL, {28'h0, rows[k].ctl}, q);
      want_nibble <= rows[k].nib;
      want_enable <= rows[k].en;
      want_error <= rows[k].err;
      sd <= rows[k].sd;
      rx_act <= rows[k].act;
      rx_vld <= rows[k].vld;
      rx_inv <= rows[k].inv;
      rx_code <= rows[k].code[4:0];
      repeat (30) @(posedge clk);
      #1;
      chk(line_tx_code, rows[k].x_code[4:0]);
      chk(line_tx_valid, rows[k].en);
      chk(collision_out, rows[k].x_col);
      chk(carrier_sense_out, rows[k].x_crs);
      chk(rx_valid_out, rows[k].x_rxv);
      chk(rx_nibble, rows[k].x_rxn);
      chk(rx_error_out, rows[k].x_rxe);
      $display("row %0d done", k);
    end
    // Half of every ten cycles high on both clocks at 10 Mbps
    cnt = 16'h0000;
    repeat (20) begin
      @(posedge clk);
      #1;
      cnt += tx_clock_out + rx_clock_out;
    end
    chk(cnt, 16'h0014);
    $display("clock rate done");
    // Strap high: pins own the bits, serial port silent
    do_reset(1'b1, 4'h2);
    av(1'b0, OFF_CTRL, 32'h0, q);
    chk(q[15:0], 16'h0002);
    av(1'b0, OFF_STAT, 32'h0, q);
    chk(q[15:0], 16'h001c);
    av(1'b1, OFF_CTRL, 32'h1, q);
    md_frame(MD_OP_WRITE, MREG_CTRL, 16'h0001, 16'h0001);
    av(1'b0, OFF_CTRL, 32'h0, q);
    chk(q[15:0], 16'h0002);
    md_frame(MD_OP_READ, MREG_ADDR, 16'h0000, 16'hffff);
    stop_test();
  end
endmodule
